/* File: usm_pkg.sv */
// constants, carriers and states of the dual-mode serial unit
`default_nettype none
package usm_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int EXP_W = 5;
	localparam int DIV_W = 32;
	localparam int IDX_W = 4;

	localparam logic [ADDR_W-1:0] OFS_RATE_MANT = 8'hc2;
	localparam logic [ADDR_W-1:0] OFS_CTRL_STAT = 8'hf8;
	localparam logic [ADDR_W-1:0] OFS_DATA_BUF = 8'hf9;
	localparam logic [ADDR_W-1:0] OFS_FRAME_CTRL = 8'hfb;
	localparam logic [ADDR_W-1:0] OFS_RATE_EXP = 8'hfc;

	// control and status bit positions
	localparam int CS_MODE = 7;
	localparam int CS_LISTEN = 6;
	localparam int CS_TARGET = 5;
	localparam int CS_FRAME = 4;
	localparam int CS_PARITY = 3;
	localparam int CS_RXBYTE = 2;
	localparam int CS_TXBYTE = 1;
	localparam int CS_ACTIVE = 0;

	// frame control bit positions
	localparam int FC_PAR_ODD = 5;
	localparam int FC_PAR_EN = 3;
	localparam int FC_TWO_STOP = 2;
	localparam int FC_STOP_LVL = 1;
	localparam int FC_START_LVL = 0;

	localparam logic [DATA_W-1:0] RATE_MANT_RESET = 8'h00;
	localparam logic [EXP_W-1:0] RATE_EXP_RESET = 5'h00;
	localparam logic [DATA_W-1:0] FRAME_CTRL_RESET = 8'h02;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
	localparam logic [DIV_W-1:0] DIV_ONE = 32'h0000_0001;
	localparam logic [IDX_W-1:0] LAST_BIT = 4'h7;
	localparam logic [IDX_W-1:0] IDX_ZERO = 4'h0;
	localparam logic [IDX_W-1:0] IDX_ONE = 4'h1;

	typedef struct packed {
		logic mode_uart;
		logic listen_enable;
		logic target;
		logic par_en;
		logic par_odd;
		logic two_stop;
		logic stop_lvl;
		logic start_lvl;
		logic [DATA_W-1:0] mant;
		logic [EXP_W-1:0] expo;
	} usm_cfg_t;

	typedef struct packed {
		logic ser_in;
		logic sck_in;
		logic sel_n;
	} usm_pins_in_t;

	typedef struct packed {
		logic ser_out;
		logic ser_oe;
		logic sck_out;
		logic sck_oe;
	} usm_pins_out_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic par_err;
		logic frame_err;
	} usm_rx_word_t;

	typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP1, R_STOP2} usm_rx_state_t;
	typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP1, T_STOP2} usm_tx_state_t;
	typedef enum logic [1:0] {S_IDLE, S_MASTER, S_TARGET} usm_spi_state_t;

endpackage
`default_nettype wire

/* File: usm_serial_unit.sv */
// dual-mode serial unit: registers on clk_sys, line engines on clk_link
`default_nettype none
module usm_serial_unit
	import usm_pkg::*;
(
	// system clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// byte received event
	output logic receive_interrupt_flag,
	// link clock and pins
	input wire logic clk_link,
	input wire usm_pins_in_t pins_in,
	output usm_pins_out_t pins_out
);

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// ---------------- system domain ----------------
	logic [DATA_W-1:0] rate_mantissa_reg;
	logic [EXP_W-1:0] rate_exp;
	logic [DATA_W-1:0] frame_ctrl;
	logic mode_uart;
	logic listen_enable;
	logic target_sel;
	logic framing_fault_flag;
	logic parity_flag;
	logic rx_byte_flag;
	logic tx_byte_flag;
	logic [DATA_W-1:0] rx_buf;
	logic [DATA_W-1:0] tx_data;
	logic tx_req_tgl;
	logic ack_meta, ack_sync;
	logic rx_meta, rx_sync, rx_prev;
	logic fe2_meta, fe2_sync, fe2_prev;
	logic txd_meta, txd_sync, txd_prev;
	logic busy_meta, busy_sync;

	// link-domain signals read across
	logic lk_req_seen;
	logic lk_rx_tgl;
	logic lk_fe2_tgl;
	logic lk_txd_tgl;
	logic lk_busy;
	usm_rx_word_t lk_rx_word;

	wire wr_mant = reg_wr && hit(reg_addr, OFS_RATE_MANT);
	wire wr_cs = reg_wr && hit(reg_addr, OFS_CTRL_STAT);
	wire wr_dbuf = reg_wr && hit(reg_addr, OFS_DATA_BUF);
	wire wr_fc = reg_wr && hit(reg_addr, OFS_FRAME_CTRL);
	wire wr_exp = reg_wr && hit(reg_addr, OFS_RATE_EXP);
	wire tx_pending = tx_req_tgl ^ ack_sync;
	wire rx_evt = rx_sync ^ rx_prev;
	wire fe2_evt = fe2_sync ^ fe2_prev;
	wire txd_evt = txd_sync ^ txd_prev;
	wire active_now = busy_sync | tx_pending;
	wire [DATA_W-1:0] cs_view = {mode_uart, listen_enable, target_sel, framing_fault_flag,
		parity_flag, rx_byte_flag, tx_byte_flag, active_now};
	wire [DATA_W-1:0] next_rdata =
		hit(reg_addr, OFS_RATE_MANT) ? rate_mantissa_reg :
		hit(reg_addr, OFS_CTRL_STAT) ? cs_view :
		hit(reg_addr, OFS_DATA_BUF) ? rx_buf :
		hit(reg_addr, OFS_FRAME_CTRL) ? frame_ctrl :
		hit(reg_addr, OFS_RATE_EXP) ? {{(DATA_W-EXP_W){1'b0}}, rate_exp} : DATA_RESET;

	wire next_fe = (fe2_evt | (rx_evt & lk_rx_word.frame_err)) |
		(framing_fault_flag & ~(wr_cs & ~reg_wdata[CS_FRAME]));
	wire next_pe = (rx_evt & lk_rx_word.par_err) |
		(parity_flag & ~(wr_cs & ~reg_wdata[CS_PARITY]));
	wire next_rxb = rx_evt | (rx_byte_flag & ~(wr_cs & ~reg_wdata[CS_RXBYTE]));
	wire next_txb = txd_evt | (tx_byte_flag & ~(wr_cs & ~reg_wdata[CS_TXBYTE]));

	always_ff @(posedge clk_sys) begin
		ack_meta <= lk_req_seen;
		ack_sync <= ack_meta;
		rx_meta <= lk_rx_tgl;
		rx_sync <= rx_meta;
		fe2_meta <= lk_fe2_tgl;
		fe2_sync <= fe2_meta;
		txd_meta <= lk_txd_tgl;
		txd_sync <= txd_meta;
		busy_meta <= lk_busy;
		busy_sync <= busy_meta;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rate_mantissa_reg <= RATE_MANT_RESET;
			rate_exp <= RATE_EXP_RESET;
			frame_ctrl <= FRAME_CTRL_RESET;
			mode_uart <= 1'b0;
			listen_enable <= 1'b0;
			target_sel <= 1'b0;
			framing_fault_flag <= 1'b0;
			parity_flag <= 1'b0;
			rx_byte_flag <= 1'b0;
			tx_byte_flag <= 1'b0;
			rx_buf <= DATA_RESET;
			tx_data <= DATA_RESET;
			tx_req_tgl <= 1'b0;
			rx_prev <= 1'b0;
			fe2_prev <= 1'b0;
			txd_prev <= 1'b0;
			reg_rdata <= DATA_RESET;
			receive_interrupt_flag <= 1'b0;
		end else begin
			rx_prev <= rx_sync;
			fe2_prev <= fe2_sync;
			txd_prev <= txd_sync;
			reg_rdata <= reg_rd ? next_rdata : DATA_RESET;
			receive_interrupt_flag <= rx_evt;
			if (wr_mant) begin
				rate_mantissa_reg <= reg_wdata;
			end
			if (wr_exp) begin
				rate_exp <= reg_wdata[EXP_W-1:0];
			end
			if (wr_fc) begin
				frame_ctrl <= reg_wdata;
			end
			if (wr_cs) begin
				mode_uart <= reg_wdata[CS_MODE];
				listen_enable <= reg_wdata[CS_LISTEN];
				target_sel <= reg_wdata[CS_TARGET];
			end
			framing_fault_flag <= next_fe;
			parity_flag <= next_pe;
			rx_byte_flag <= next_rxb;
			tx_byte_flag <= next_txb;
			if (rx_evt) begin
				rx_buf <= lk_rx_word.data;
			end
			if (wr_dbuf && !tx_pending) begin
				tx_data <= reg_wdata;
				tx_req_tgl <= ~tx_req_tgl;
			end
		end
	end

	// ---------------- link domain ----------------
	logic lk_rst_meta, lk_rst;
	usm_cfg_t cfg_meta, cfg;
	usm_pins_in_t pin_meta, pin_sync;
	logic sck_prev;
	logic req_meta, req_sync;
	usm_rx_state_t rx_state;
	usm_tx_state_t tx_state;
	usm_spi_state_t spi_state;
	logic [DIV_W-1:0] rx_cnt, tx_cnt, spi_cnt;
	logic [IDX_W-1:0] rx_idx, tx_idx, spi_idx;
	logic [DATA_W-1:0] rx_sh, tx_sh, spi_sh;
	logic rx_par, tx_par, spi_samp, tx_line, sck_gen;

	wire usm_cfg_t cfg_src = '{mode_uart: mode_uart, listen_enable: listen_enable,
		target: target_sel, par_en: frame_ctrl[FC_PAR_EN], par_odd: frame_ctrl[FC_PAR_ODD],
		two_stop: frame_ctrl[FC_TWO_STOP], stop_lvl: frame_ctrl[FC_STOP_LVL],
		start_lvl: frame_ctrl[FC_START_LVL], mant: rate_mantissa_reg, expo: rate_exp};
	// bit period from mantissa and exponent
	wire [DIV_W-1:0] bit_cycles = (DIV_W'(cfg.mant) + DIV_ONE) << cfg.expo;
	wire [DIV_W-1:0] full_ld = bit_cycles - DIV_ONE;
	wire [DIV_W-1:0] half_ld = bit_cycles >> 1;
	wire rx_in = pin_sync.ser_in;
	wire take = (req_sync != lk_req_seen) && tx_state == T_IDLE &&
		(spi_state == S_IDLE);
	wire sck_rise = pin_sync.sck_in & ~sck_prev;
	wire sck_fall = ~pin_sync.sck_in & sck_prev;
	wire rx_tick = (rx_cnt == '0);
	wire tx_tick = (tx_cnt == '0);
	wire spi_tick = (spi_cnt == '0);
	wire stop_bad = (rx_in != cfg.stop_lvl);
	wire usm_pins_out_t next_pins = '{
		ser_out: cfg.mode_uart ? tx_line : spi_sh[0],
		ser_oe: cfg.mode_uart | ~cfg.target | ~pin_sync.sel_n,
		sck_out: sck_gen,
		sck_oe: ~cfg.mode_uart & ~cfg.target};

	always_ff @(posedge clk_link) begin
		lk_rst_meta <= srst;
		lk_rst <= lk_rst_meta;
		cfg_meta <= cfg_src;
		cfg <= cfg_meta;
		pin_meta <= pins_in;
		pin_sync <= pin_meta;
		sck_prev <= pin_sync.sck_in;
		req_meta <= tx_req_tgl;
		req_sync <= req_meta;
	end

	// receiver
	always_ff @(posedge clk_link) begin
		if (lk_rst) begin
			rx_state <= R_IDLE;
			rx_cnt <= '0;
			rx_idx <= IDX_ZERO;
			rx_sh <= DATA_RESET;
			rx_par <= 1'b0;
		end else begin
			rx_cnt <= rx_tick ? full_ld : rx_cnt - DIV_ONE;
			unique case (rx_state)
				R_IDLE: begin
					if (cfg.mode_uart && cfg.listen_enable && rx_in == cfg.start_lvl) begin
						rx_state <= R_START;
						rx_cnt <= half_ld;
					end
				end
				R_START: begin
					if (rx_tick) begin
						rx_state <= (rx_in == cfg.start_lvl) ? R_DATA : R_IDLE;
						rx_idx <= IDX_ZERO;
						rx_par <= cfg.par_odd;
					end
				end
				R_DATA: begin
					if (rx_tick) begin
						rx_sh <= {rx_in, rx_sh[DATA_W-1:1]};
						rx_par <= rx_par ^ rx_in;
						rx_idx <= rx_idx + IDX_ONE;
						if (rx_idx == LAST_BIT) begin
							rx_state <= cfg.par_en ? R_PAR : R_STOP1;
						end
					end
				end
				R_PAR: begin
					if (rx_tick) begin
						rx_par <= rx_par ^ rx_in;
						rx_state <= R_STOP1;
					end
				end
				R_STOP1: begin
					if (rx_tick) begin
						rx_state <= (cfg.two_stop && !stop_bad) ? R_STOP2 : R_IDLE;
					end
				end
				R_STOP2: begin
					if (rx_tick) begin
						rx_state <= R_IDLE;
					end
				end
			endcase
			if (rx_state != R_IDLE && !(cfg.mode_uart && cfg.listen_enable)) begin
				rx_state <= R_IDLE;
			end
		end
	end

	// transmitter and spi engine
	always_ff @(posedge clk_link) begin
		if (lk_rst) begin
			tx_state <= T_IDLE;
			spi_state <= S_IDLE;
			tx_cnt <= '0;
			spi_cnt <= '0;
			tx_idx <= IDX_ZERO;
			spi_idx <= IDX_ZERO;
			tx_sh <= DATA_RESET;
			spi_sh <= DATA_RESET;
			tx_par <= 1'b0;
			spi_samp <= 1'b0;
			tx_line <= 1'b1;
			sck_gen <= 1'b0;
			lk_req_seen <= 1'b0;
			lk_rx_tgl <= 1'b0;
			lk_fe2_tgl <= 1'b0;
			lk_txd_tgl <= 1'b0;
			lk_rx_word <= '0;
			lk_busy <= 1'b0;
			pins_out <= '0;
		end else begin
			pins_out <= next_pins;
			// busy from take on, no gap after the hand-over acknowledge
			lk_busy <= (rx_state != R_IDLE) || (tx_state != T_IDLE) || (spi_state != S_IDLE) ||
				take;
			tx_cnt <= tx_tick ? full_ld : tx_cnt - DIV_ONE;
			spi_cnt <= spi_tick ? full_ld : spi_cnt - DIV_ONE;
			if (take) begin
				lk_req_seen <= req_sync;
			end
			if (rx_state == R_STOP1 && rx_tick) begin
				lk_rx_word <= '{data: rx_sh, par_err: cfg.par_en & rx_par, frame_err: stop_bad};
				lk_rx_tgl <= ~lk_rx_tgl;
			end
			if (rx_state == R_STOP2 && rx_tick && stop_bad) begin
				lk_fe2_tgl <= ~lk_fe2_tgl;
			end
			unique case (tx_state)
				T_IDLE: begin
					tx_line <= ~cfg.start_lvl;
					if (take && cfg.mode_uart) begin
						tx_sh <= tx_data;
						tx_state <= T_START;
						tx_cnt <= full_ld;
						tx_line <= cfg.start_lvl;
						tx_idx <= IDX_ZERO;
						tx_par <= cfg.par_odd;
					end
				end
				T_START: begin
					if (tx_tick) begin
						tx_state <= T_DATA;
						tx_line <= tx_sh[0];
						tx_par <= tx_par ^ tx_sh[0];
					end
				end
				T_DATA: begin
					if (tx_tick) begin
						tx_sh <= tx_sh >> 1;
						tx_idx <= tx_idx + IDX_ONE;
						tx_line <= tx_sh[1];
						tx_par <= tx_par ^ tx_sh[1];
						if (tx_idx == LAST_BIT) begin
							tx_state <= cfg.par_en ? T_PAR : T_STOP1;
							tx_line <= cfg.par_en ? tx_par : cfg.stop_lvl;
						end
					end
				end
				T_PAR: begin
					if (tx_tick) begin
						tx_state <= T_STOP1;
						tx_line <= cfg.stop_lvl;
					end
				end
				T_STOP1: begin
					if (tx_tick) begin
						tx_state <= cfg.two_stop ? T_STOP2 : T_IDLE;
					end
				end
				T_STOP2: begin
					if (tx_tick) begin
						tx_state <= T_IDLE;
					end
				end
			endcase
			if ((tx_state == T_STOP1 && tx_tick && !cfg.two_stop) ||
				(tx_state == T_STOP2 && tx_tick)) begin
				lk_txd_tgl <= ~lk_txd_tgl;
			end
			// master or target shifting, lsb first, sample on rise
			unique case (spi_state)
				S_IDLE: begin
					sck_gen <= 1'b0;
					spi_idx <= IDX_ZERO;
					if (take && !cfg.mode_uart) begin
						spi_sh <= tx_data;
						spi_cnt <= full_ld;
						spi_state <= cfg.target ? S_IDLE : S_MASTER;
					end
					if (!cfg.mode_uart && cfg.target && !pin_sync.sel_n) begin
						spi_state <= S_TARGET;
					end
				end
				S_MASTER: begin
					if (spi_tick) begin
						sck_gen <= ~sck_gen;
						if (!sck_gen) begin
							spi_samp <= pin_sync.ser_in;
						end else begin
							spi_sh <= {spi_samp, spi_sh[DATA_W-1:1]};
							spi_idx <= spi_idx + IDX_ONE;
						end
					end
				end
				S_TARGET: begin
					if (sck_rise) begin
						spi_samp <= pin_sync.ser_in;
					end
					if (sck_fall) begin
						spi_sh <= {spi_samp, spi_sh[DATA_W-1:1]};
						spi_idx <= spi_idx + IDX_ONE;
					end
					if (pin_sync.sel_n) begin
						spi_state <= S_IDLE;
					end
				end
			endcase
			if (spi_state != S_IDLE && spi_idx == LAST_BIT + IDX_ONE) begin
				spi_state <= S_IDLE;
				lk_rx_word <= '{data: spi_sh, par_err: 1'b0, frame_err: 1'b0};
				lk_rx_tgl <= ~lk_rx_tgl;
				lk_txd_tgl <= ~lk_txd_tgl;
			end
		end
	end

endmodule // usm_serial_unit
`default_nettype wire

/* File: usm_checker.sv */
// assertions on the register port of the serial unit
`default_nettype none
module usm_checker
	import usm_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// byte event
	input wire logic receive_interrupt_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	wire wr_mant = reg_wr && reg_addr == OFS_RATE_MANT;
	wire rd_mant = reg_rd && reg_addr == OFS_RATE_MANT;
	wire wr_cs = reg_wr && reg_addr == OFS_CTRL_STAT;
	wire rd_cs = reg_rd && reg_addr == OFS_CTRL_STAT;
	wire rd_exp = reg_rd && reg_addr == OFS_RATE_EXP;
	property p_mant_back;
		wr_mant ##1 rd_mant |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_mant_back: assert property (p_mant_back)
		else $error("mantissa readback wrong");
	property p_exp_upper;
		rd_exp |=> reg_rdata[7:5] == 3'b000;
	endproperty
	a_exp_upper: assert property (p_exp_upper)
		else $error("exponent upper bits set");
	property p_ctrl_back;
		wr_cs ##1 rd_cs |=> ((reg_rdata ^ $past(reg_wdata, 2)) & 8'he0) == 8'h00;
	endproperty
	a_ctrl_back: assert property (p_ctrl_back)
		else $error("mode bits readback wrong");
	property p_active_ro;
		wr_cs && reg_wdata == 8'h01 ##1 rd_cs |=> reg_rdata == 8'h00;
	endproperty
	a_active_ro: assert property (p_active_ro)
		else $error("activity bit took a write");
	property p_reset_zero;
		$fell(srst) && rd_cs |=> reg_rdata == 8'h00;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("status not zero after reset");
	property p_rx_flag;
		receive_interrupt_flag ##1 rd_cs |=> reg_rdata[CS_RXBYTE];
	endproperty
	a_rx_flag: assert property (p_rx_flag)
		else $error("byte flag missing after event");
	property p_pulse;
		receive_interrupt_flag |=> !receive_interrupt_flag;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("byte event longer than a cycle");
	property p_quiet;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("read data outside read cycle");
endmodule // usm_checker
bind usm_serial_unit usm_checker u_chk (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .receive_interrupt_flag);
`default_nettype wire

/* File: usm_peer.sv */
// remote serial peer: drives the receive line, decodes the transmit line
`default_nettype none
module usm_peer (
	// link clock
	input wire logic clk_link,
	// lines to and from the unit
	input wire logic tx_line,
	output logic rx_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// link cycles per bit at mantissa 3, exponent 0
	localparam int PER = 4;
	initial rx_line = 1'b1;
	// start in bit 0, lsb first; line pulled up after
	task automatic send(input logic [10:0] f);
		@(posedge clk_link);
		for (int i = 0; i < 11; i++) begin
			rx_line <= f[i];
			repeat (PER) @(posedge clk_link);
		end
		rx_line <= 1'b1;
	endtask
	// samples each data bit at its centre
	task automatic take(output logic [7:0] b);
		@(negedge tx_line);
		repeat (PER / 2) @(posedge clk_link);
		for (int i = 0; i < 8; i++) begin
			repeat (PER) @(posedge clk_link);
			b[i] = tx_line;
		end
	endtask
endmodule // usm_peer
`default_nettype wire

/* File: usm_serial_unit_test.sv */
// self-checking bench of the serial unit
`default_nettype none
module usm_serial_unit_test;
	import usm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, clk_link, srst, reg_wr, reg_rd, line, receive_interrupt_flag;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
	usm_pins_in_t pins_in;
	usm_pins_out_t pins_out;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	assign pins_in = '{ser_in: line, sck_in: 1'b0, sel_n: 1'b1};
	usm_serial_unit uut (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.receive_interrupt_flag, .clk_link, .pins_in, .pins_out);
	usm_peer peer (.clk_link, .tx_line(pins_out.ser_out), .rx_line(line));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		clk_link = 1'b0;
		#7;
		forever #15 clk_link = ~clk_link;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			test_done;
		end
	end
	task cmpv(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task ck(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata & m;
		@(posedge clk_sys);
		cmpv(d, e);
	endtask
	// frame from the peer, then wait for the byte event
	task sendf(input logic [10:0] f);
		int i;
		fork
			peer.send(f);
		join_none
		for (i = 0; i < 2000 && receive_interrupt_flag !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		cmpv(8'(i < 2000), 8'h01);
	endtask
	task t_reset;
		ck(OFS_CTRL_STAT, 8'hff, 8'h00);
		ck(OFS_RATE_MANT, 8'hff, 8'h00);
		ck(OFS_RATE_EXP, 8'hff, 8'h00);
		$display("reset test done");
	endtask
	task t_regs;
		wr(OFS_RATE_MANT, 8'ha5);
		ck(OFS_RATE_MANT, 8'hff, 8'ha5);
		wr(OFS_RATE_EXP, 8'hff);
		ck(OFS_RATE_EXP, 8'hff, 8'h1f);
		wr(OFS_CTRL_STAT, 8'he0);
		ck(OFS_CTRL_STAT, 8'hff, 8'he0);
		wr(OFS_CTRL_STAT, 8'h01);
		ck(OFS_CTRL_STAT, 8'hff, 8'h00);
		wr(8'h00, 8'h5a);
		ck(8'h00, 8'hff, 8'h00);
		wr(OFS_RATE_MANT, 8'h03);
		@(posedge clk_sys);
		wr(OFS_RATE_EXP, 8'h00);
		$display("register test done");
	endtask
	task t_tx;
		wr(OFS_CTRL_STAT, 8'h80);
		repeat (20) @(posedge clk_sys);
		fork
			peer.take(b);
			begin
				wr(OFS_DATA_BUF, 8'h3c);
				repeat (40) @(posedge clk_sys);
				ck(OFS_CTRL_STAT, 8'h03, 8'h01);
			end
		join
		@(posedge clk_sys);
		cmpv(b, 8'h3c);
		repeat (80) @(posedge clk_sys);
		ck(OFS_CTRL_STAT, 8'h03, 8'h02);
		wr(OFS_CTRL_STAT, 8'h80);
		ck(OFS_CTRL_STAT, 8'hff, 8'h80);
		$display("transmit test done");
	endtask
	task t_rx;
		peer.send({2'b11, 8'h55, 1'b0});
		repeat (20) @(posedge clk_sys);
		ck(OFS_CTRL_STAT, 8'h04, 8'h00);
		wr(OFS_CTRL_STAT, 8'hc0);
		repeat (20) @(posedge clk_sys);
		sendf({2'b11, 8'h96, 1'b0});
		ck(OFS_CTRL_STAT, 8'h1c, 8'h04);
		ck(OFS_DATA_BUF, 8'hff, 8'h96);
		$display("receive test done");
	endtask
	task t_errors;
		repeat (40) @(posedge clk_sys);
		wr(OFS_CTRL_STAT, 8'hc0);
		@(posedge clk_sys);
		wr(OFS_FRAME_CTRL, 8'h0a);
		repeat (20) @(posedge clk_sys);
		sendf({1'b1, 1'b0, 8'h01, 1'b0});
		ck(OFS_CTRL_STAT, 8'h1c, 8'h0c);
		repeat (40) @(posedge clk_sys);
		wr(OFS_CTRL_STAT, 8'hc0);
		@(posedge clk_sys);
		wr(OFS_FRAME_CTRL, 8'h06);
		repeat (20) @(posedge clk_sys);
		sendf({1'b0, 1'b1, 8'h5a, 1'b0});
		ck(OFS_CTRL_STAT, 8'h1c, 8'h04);
		repeat (40) @(posedge clk_sys);
		ck(OFS_CTRL_STAT, 8'h10, 8'h10);
		$display("error test done");
	endtask
	// spi master byte: clock count, drivers, both flags, byte from the idle line
	task t_spi;
		int k;
		int n;
		logic p;
		wr(OFS_CTRL_STAT, 8'h00);
		repeat (40) @(posedge clk_sys);
		wr(OFS_DATA_BUF, 8'h81);
		n = 0;
		p = 1'b0;
		for (k = 0; k < 600; k++) begin
			@(posedge clk_sys);
			#1;
			if (k == 300) begin
				cmpv({6'h00, pins_out.sck_oe, pins_out.ser_oe}, 8'h03);
			end
			n += int'(pins_out.sck_out && !p);
			p = pins_out.sck_out;
		end
		@(posedge clk_sys);
		cmpv(8'(n), 8'h08);
		ck(OFS_CTRL_STAT, 8'hff, 8'h06);
		ck(OFS_DATA_BUF, 8'hff, 8'hff);
		$display("spi test done");
	endtask
	task test_done;
		$display("mismatches %0d compares %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		// long enough for the link side reset too
		repeat (32) @(posedge clk_sys);
		srst <= 1'b0;
		t_reset;
		t_regs;
		t_tx;
		t_rx;
		t_errors;
		t_spi;
		test_done;
	end
endmodule // usm_serial_unit_test
`default_nettype wire
